// *** rtl/tslc_map.svh ***
/*
  Register indices, field positions, reset values and event bit positions
  of the shunt limit and sum block.
  Assumes a bus whose byte address is four times the register index.
*/
`ifndef TSLC_MAP_SVH
`define TSLC_MAP_SVH

`define TSLC_NCH 3
`define TSLC_IDX_W 8
`define TSLC_IDX_LSB 2
`define TSLC_IDX_MSB 9

`define TSLC_IDX_CH1_FAST 8'h07
`define TSLC_IDX_CH1_SLOW 8'h08
`define TSLC_IDX_CH2_FAST 8'h09
`define TSLC_IDX_CH2_SLOW 8'h0A
`define TSLC_IDX_CH3_FAST 8'h0B
`define TSLC_IDX_CH3_SLOW 8'h0C
`define TSLC_IDX_SUM 8'h0D
`define TSLC_IDX_IRQ_STAT 8'h10
`define TSLC_IDX_IRQ_CLR 8'h11
`define TSLC_IDX_IRQ_EN 8'h12

`define TSLC_LIMIT_RST 16'h7FF8
`define TSLC_LIMIT_MASK 16'hFFF8
`define TSLC_SUM_RST 16'h0000
`define TSLC_LIM_HI 15
`define TSLC_LIM_LO 3
`define TSLC_SUM_HI 15
`define TSLC_SUM_LO 1
`define TSLC_SUM_RSV 1'h0

`define TSLC_EVT_W 8
`define TSLC_EVT_FAST_LO 0
`define TSLC_EVT_SLOW_LO 3
`define TSLC_EVT_SUM_TRIP 6
`define TSLC_EVT_SUM_UPD 7
`define TSLC_EN_RST 8'h00

`endif

// *** rtl/tslc_pkg.sv ***
/*
  Types shared by the shunt limit and sum block.
  Assumes nothing of its surroundings.
*/
package tslc_pkg;
  // Channel value aligned on the sum grid: 40 uV per step
  typedef logic signed [14:0] tslc_val_t;
  typedef logic [15:0] tslc_reg_t;
  // Bus slave read sequencing
  typedef enum logic [1:0] {
    TSLC_BUS_IDLE,
    TSLC_BUS_RD_WAIT,
    TSLC_BUS_RD_DONE
  } tslc_bus_state_t;
endpackage : tslc_pkg

// *** rtl/tslc_top.sv ***
/*
  Limit registers, shunt sum and compare logic of a three-channel current
  monitor, with an AHB-Lite register slave and a masked interrupt.
  Assumes conversion results, the cycle-complete strobe, the channel
  select bits and the sum limit come from logic on sys_clk_i.
*/
`timescale 1ns/100ps
`include "tslc_map.svh"

// Functional notes
// [RULE1] Every single conversion is checked against its channel's fast limit.
// [RULE2] Averaged results are checked against the channel's slow limit.
// [RULE3] Limit registers hold a 13-bit value in bits 15-3; bits 2-0 reserved.
// [RULE4] Limits reset to 7FF8h.
// [RULE5] The total sums single conversions of selected channels only.
// [RULE6] The total register updates once per completed measurement cycle.
// [RULE7] Total: sign on top, 14-bit magnitude in bits 14-1, 40 uV step.
// [RULE8] Total top bit is 0 when positive, 1 when negative two's complement.
// [RULE9] The total register is read-only and resets to zero.
// [RULE10] A select bit of 1 includes its channel; default excluded.
// [RULE11] A conversion above its fast limit sets its flag and critical alert.
// [RULE12] An average above its slow limit sets its flag and warning alert.
// [RULE13] After each completed cycle the total is checked against the limit.
// [RULE14] Compares are signed, aligned, and trip only on strictly greater.
// [RULE15] Reserved bits read zero and never affect compares or sums.
module tslc_top
  import tslc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic raw_valid_i,
  input wire logic [1:0] raw_chan_i,
  input wire logic [15:0] raw_data_i,
  input wire logic avg_valid_i,
  input wire logic [1:0] avg_chan_i,
  input wire logic [15:0] avg_data_i,
  input wire logic cycle_done_i,
  input wire logic [2:0] sum_channel_select_i,
  input wire logic [15:0] sum_limit_i,
  output logic [2:0] fast_trip_flags_o,
  output logic [2:0] slow_trip_flags_o,
  output logic sum_trip_o,
  output logic crit_alert_o,
  output logic warn_alert_o,
  output logic irq_o
);

  // Limit field in bits 15-3, sign-extended onto the 40 uV grid
  function automatic tslc_val_t lim_val(input tslc_reg_t r);
    lim_val = {{2{r[`TSLC_LIM_HI]}}, r[`TSLC_LIM_HI:`TSLC_LIM_LO]}; // [RULE15]
  endfunction : lim_val

  // Sum field in bits 15-1; bit 0 carries no weight
  function automatic tslc_val_t sum_val(input tslc_reg_t r);
    sum_val = r[`TSLC_SUM_HI:`TSLC_SUM_LO]; // [RULE15]
  endfunction : sum_val

  // Strictly greater, both operands signed on one grid
  function automatic logic over(input tslc_val_t m, input tslc_val_t l);
    over = (m > l); // [RULE14]
  endfunction : over

  tslc_reg_t fast_limit [`TSLC_NCH];
  tslc_reg_t slow_limit [`TSLC_NCH];
  tslc_reg_t total;
  tslc_val_t acc;
  tslc_val_t add_term;
  tslc_val_t next_total;
  logic next_sum_trip;
  logic [`TSLC_EVT_W-1:0] stat;
  logic [`TSLC_EVT_W-1:0] irq_en;
  logic [`TSLC_EVT_W-1:0] evt;
  logic [`TSLC_EVT_W-1:0] clr;
  logic [2:0] fast_hit;
  logic [2:0] slow_hit;
  tslc_bus_state_t bus_state;
  logic addr_take;
  logic wr_pend;
  logic [`TSLC_IDX_W-1:0] wr_idx;
  logic [`TSLC_IDX_W-1:0] rd_idx;
  logic [`TSLC_IDX_W-1:0] addr_idx;
  logic [31:0] rd_mux;

  // Address phase is taken only when the bus is ready and the slot is ours
  assign addr_idx = haddr_i[`TSLC_IDX_MSB:`TSLC_IDX_LSB];
  assign addr_take = hsel_i && htrans_i[1] && hready_i;
  assign hresp_o = 1'b0;

  // Reads insert one wait state so a write just before is always visible
  assign hreadyout_o = (bus_state != TSLC_BUS_RD_WAIT);

  // Bus sequencing for reads
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_state <= TSLC_BUS_IDLE;
      rd_idx <= '0;
    end
    else
    begin
      case (bus_state)
        TSLC_BUS_RD_WAIT:
          bus_state <= TSLC_BUS_RD_DONE;
        TSLC_BUS_IDLE, TSLC_BUS_RD_DONE:
        begin
          if (addr_take && !hwrite_i)
          begin
            bus_state <= TSLC_BUS_RD_WAIT;
            rd_idx <= addr_idx;
          end
          else
          begin
            bus_state <= TSLC_BUS_IDLE;
          end
        end
        default:
          bus_state <= TSLC_BUS_IDLE;
      endcase
    end
  end

  // Pending write carried into its data phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
    end
    else
    begin
      wr_pend <= addr_take && hwrite_i;
      if (addr_take && hwrite_i)
      begin
        wr_idx <= addr_idx;
      end
    end
  end

  // Read decode; unmapped and write-only addresses read zero
  always_comb
  begin
    rd_mux = '0;
    case (rd_idx)
      `TSLC_IDX_CH1_FAST: rd_mux[15:0] = fast_limit[0];
      `TSLC_IDX_CH1_SLOW: rd_mux[15:0] = slow_limit[0];
      `TSLC_IDX_CH2_FAST: rd_mux[15:0] = fast_limit[1];
      `TSLC_IDX_CH2_SLOW: rd_mux[15:0] = slow_limit[1];
      `TSLC_IDX_CH3_FAST: rd_mux[15:0] = fast_limit[2];
      `TSLC_IDX_CH3_SLOW: rd_mux[15:0] = slow_limit[2];
      `TSLC_IDX_SUM: rd_mux[15:0] = total;
      `TSLC_IDX_IRQ_STAT: rd_mux[`TSLC_EVT_W-1:0] = stat;
      `TSLC_IDX_IRQ_EN: rd_mux[`TSLC_EVT_W-1:0] = irq_en;
      default: rd_mux = '0;
    endcase
  end

  // Read data is registered in the wait cycle and held afterwards
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hrdata_o <= '0;
    end
    else if (bus_state == TSLC_BUS_RD_WAIT)
    begin
      hrdata_o <= rd_mux;
    end
  end

  // Limit registers; a write stores bits 15-3 and keeps 2-0 at zero
  generate
    for (genvar c = 0; c < `TSLC_NCH; c++)
    begin : g_limit
      localparam logic [`TSLC_IDX_W-1:0] FAST_IDX =
        `TSLC_IDX_W'(`TSLC_IDX_CH1_FAST + 2 * c); // [RULE1]
      localparam logic [`TSLC_IDX_W-1:0] SLOW_IDX =
        `TSLC_IDX_W'(`TSLC_IDX_CH1_SLOW + 2 * c); // [RULE2]

      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          fast_limit[c] <= `TSLC_LIMIT_RST; // [RULE4]
          slow_limit[c] <= `TSLC_LIMIT_RST; // [RULE4]
        end
        else if (wr_pend)
        begin
          if (wr_idx == FAST_IDX)
          begin
            fast_limit[c] <= hwdata_i[15:0] & `TSLC_LIMIT_MASK; // [RULE3]
          end
          if (wr_idx == SLOW_IDX)
          begin
            slow_limit[c] <= hwdata_i[15:0] & `TSLC_LIMIT_MASK; // [RULE3]
          end
        end
      end

      // Per-channel compares, each on the result that belongs to it
      assign fast_hit[c] = raw_valid_i && (raw_chan_i == 2'(c)) &&
        over(lim_val(raw_data_i), lim_val(fast_limit[c])); // [RULE1]
      assign slow_hit[c] = avg_valid_i && (avg_chan_i == 2'(c)) &&
        over(lim_val(avg_data_i), lim_val(slow_limit[c])); // [RULE2]

      // Flags follow the latest result of their own channel
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          fast_trip_flags_o[c] <= 1'b0;
          slow_trip_flags_o[c] <= 1'b0;
        end
        else
        begin
          if (raw_valid_i && (raw_chan_i == 2'(c)))
          begin
            fast_trip_flags_o[c] <= fast_hit[c]; // [RULE11]
          end
          if (avg_valid_i && (avg_chan_i == 2'(c)))
          begin
            slow_trip_flags_o[c] <= slow_hit[c]; // [RULE12]
          end
        end
      end
    end
  endgenerate

  // Only selected channels feed the running total; channel 3 index unused
  always_comb
  begin
    add_term = '0;
    if (raw_valid_i && (raw_chan_i < 2'(`TSLC_NCH)))
    begin
      if (sum_channel_select_i[raw_chan_i]) // [RULE10]
      begin
        add_term = lim_val(raw_data_i); // [RULE5]
      end
    end
  end

  // A conversion landing with the cycle strobe still counts in this cycle
  assign next_total = 15'(acc + add_term); // [RULE7]
  assign next_sum_trip = over(next_total, sum_val(sum_limit_i)); // [RULE13]

  // Running accumulator, restarted at every completed cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc <= '0;
    end
    else if (cycle_done_i)
    begin
      acc <= '0;
    end
    else
    begin
      acc <= next_total; // [RULE5]
    end
  end

  // Total register moves only on a completed cycle, never mid-cycle.
  // Three 13-bit values cannot overflow the 15-bit field.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      total <= `TSLC_SUM_RST; // [RULE9]
      sum_trip_o <= 1'b0;
    end
    else if (cycle_done_i)
    begin
      total <= {next_total, `TSLC_SUM_RSV}; // [RULE6] [RULE8]
      sum_trip_o <= next_sum_trip; // [RULE13]
    end
  end

  // Critical covers fast trips and the sum trip; warning the slow trips
  assign crit_alert_o = |fast_trip_flags_o || sum_trip_o; // [RULE11]
  assign warn_alert_o = |slow_trip_flags_o; // [RULE12]

  // Interrupt events, one pulse each
  always_comb
  begin
    evt = '0;
    evt[`TSLC_EVT_FAST_LO +: 3] = fast_hit;
    evt[`TSLC_EVT_SLOW_LO +: 3] = slow_hit;
    evt[`TSLC_EVT_SUM_TRIP] = cycle_done_i && next_sum_trip;
    evt[`TSLC_EVT_SUM_UPD] = cycle_done_i;
  end

  // Write-one-to-clear strobe from the clear register
  always_comb
  begin
    clr = '0;
    if (wr_pend && (wr_idx == `TSLC_IDX_IRQ_CLR))
    begin
      clr = hwdata_i[`TSLC_EVT_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat <= '0;
    end
    else
    begin
      stat <= (stat & ~clr) | evt;
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_en <= `TSLC_EN_RST;
    end
    else if (wr_pend && (wr_idx == `TSLC_IDX_IRQ_EN))
    begin
      irq_en <= hwdata_i[`TSLC_EVT_W-1:0];
    end
  end

  // Level interrupt while any enabled status bit stands
  assign irq_o = |(stat & irq_en);

endmodule : tslc_top

// *** verif/tb_tslc_top.sv ***
/*
  Self-checking bench of tslc_top: random limits, conversions and sums
  checked against bench-side models.
  Assumes tslc_host_model drives the register bus.
*/
`timescale 1ns/100ps
module tb_tslc_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [1:0] htrans_i, raw_chan_i = 2'h0, avg_chan_i = 2'h0;
  logic [2:0] hsize_i, fast_trip_flags_o, slow_trip_flags_o;
  logic [2:0] sum_channel_select_i = 3'h0;
  logic [15:0] raw_data_i = 16'h0, avg_data_i = 16'h0;
  logic [15:0] sum_limit_i = 16'h0, tot = 16'h0;
  logic raw_valid_i = 1'b0, avg_valid_i = 1'b0, cycle_done_i = 1'b0;
  logic sum_trip_o, crit_alert_o, warn_alert_o;
  logic [15:0] lim [0:5];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  wire hready_i = hreadyout_o;
  always #2.5 sys_clk_i = ~sys_clk_i;
  tslc_top dut (.*);
  tslc_host_model host (.clk_i(sys_clk_i), .hready_i(hready_i),
    .hrdata_i(hrdata_o), .hsel_o(hsel_i), .haddr_o(haddr_i),
    .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i),
    .hwdata_o(hwdata_i));
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // A hang ends the run as a mismatch
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic gt(logic [15:0] a, logic [15:0] b);
    return $signed(a[15:3]) > $signed(b[15:3]);
  endfunction : gt
  task automatic wr(logic [7:0] i, logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, i, d, x);
  endtask : wr
  task automatic rdc(string n, logic [7:0] i, logic [31:0] e);
    logic [31:0] x;
    host.xfer(1'b0, i, 32'h0, x);
    chk(n, e, x);
  endtask : rdc
  // One strobe cycle, k = {done, avg, raw}; data inverted once stale
  task automatic conv(logic [2:0] k, logic [1:0] c, logic [15:0] d);
    @(posedge sys_clk_i);
    {cycle_done_i, avg_valid_i, raw_valid_i} <= k;
    raw_chan_i <= c;
    avg_chan_i <= c;
    raw_data_i <= d;
    avg_data_i <= d;
    @(posedge sys_clk_i);
    {cycle_done_i, avg_valid_i, raw_valid_i} <= 3'h0;
    raw_data_i <= ~d;
    avg_data_i <= ~d;
    #1;
  endtask : conv
  initial
  begin
    logic [31:0] r;
    logic [15:0] d;
    logic signed [14:0] acc;
    int c;
    int a;
    void'($urandom(69));
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc("reset", 8'(7 + i), i < 6 ? 32'h7FF8 : 32'h0);
    // The slave never signals an error response
    chk("hresp", 32'h0, {31'h0, hresp_o});
    wr(8'h0D, 32'hFFFF);
    rdc("total_ro", 8'h0D, 32'h0);
    rdc("unmapped", 8'h3F, 32'h0);
    // Reserved and upper bits are written as ones on purpose
    for (int i = 0; i < 6; i++)
    begin
      lim[i] = 16'($urandom()) & 16'hFFF8;
      wr(8'(7 + i), {16'hFFFF, lim[i] | 16'h0007});
      rdc("limit", 8'(7 + i), {16'h0, lim[i]});
    end
    // Equal values first, then the floor, then random results
    for (int n = 0; n < 40; n++)
    begin
      c = n % 3;
      a = n % 2;
      d = n < 6 ? lim[2 * c + a] : n < 9 ? 16'h8000 : 16'($urandom());
      conv(a ? 3'h2 : 3'h1, 2'(c), d);
      if (a)
        chk("slow", gt(d, lim[2 * c + 1]), slow_trip_flags_o[c]);
      else
        chk("fast", gt(d, lim[2 * c]), fast_trip_flags_o[c]);
    end
    // Every select code; the total waits for the cycle strobe
    for (int n = 0; n < 8; n++)
    begin
      sum_channel_select_i <= 3'(n);
      sum_limit_i <= n == 7 ? 16'h7FFE : 16'($urandom());
      acc = 15'h0;
      for (c = 0; c < 3; c++)
      begin
        d = 16'($urandom());
        conv(3'h1, 2'(c), d);
        if (sum_channel_select_i[c])
          acc += {{2{d[15]}}, d[15:3]};
      end
      rdc("total_held", 8'h0D, {16'h0, tot});
      conv(3'h4, 2'h0, 16'h0);
      tot = {acc, 1'b0};
      rdc("total", 8'h0D, {16'h0, tot});
      chk("sum_trip", $signed(tot[15:1]) > $signed(sum_limit_i[15:1]),
        sum_trip_o);
    end
    // Total-updated event: raise, mask, clear
    wr(8'h11, 32'hFF);
    wr(8'h12, 32'h80);
    conv(3'h4, 2'h0, 16'h0);
    @(posedge sys_clk_i);
    #1;
    chk("irq_set", 1'b1, irq_o);
    wr(8'h12, 32'h0);
    @(posedge sys_clk_i);
    #1;
    chk("irq_mask", 1'b0, irq_o);
    wr(8'h12, 32'h80);
    wr(8'h11, 32'h80);
    @(posedge sys_clk_i);
    #1;
    chk("irq_clr", 1'b0, irq_o);
    host.xfer(1'b0, 8'h10, 32'h0, r);
    chk("stat_clr", 1'b0, r[7]);
    give_verdict();
  end
endmodule : tb_tslc_top

// *** verif/tslc_chk_sva.sv ***
/*
  Port checker for tslc_top: alert ORs, flag and trip hold times, bus
  wait states and strict compare corners.
  Assumes it is bound to tslc_top and sees only its ports.
*/
`timescale 1ns/100ps
module tslc_chk (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic raw_valid_i,
  input wire logic [1:0] raw_chan_i,
  input wire logic [15:0] raw_data_i,
  input wire logic avg_valid_i,
  input wire logic [1:0] avg_chan_i,
  input wire logic [15:0] avg_data_i,
  input wire logic cycle_done_i,
  input wire logic [15:0] sum_limit_i,
  input wire logic [2:0] fast_trip_flags_o,
  input wire logic [2:0] slow_trip_flags_o,
  input wire logic sum_trip_o,
  input wire logic crit_alert_o,
  input wire logic warn_alert_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Alerts follow the flag registers with no extra delay
  crit_alert_or_a: assert property (crit_alert_o ==
    (|fast_trip_flags_o | sum_trip_o)) else $error("crit alert wrong");
  warn_alert_or_a: assert property (warn_alert_o ==
    |slow_trip_flags_o) else $error("warn alert wrong");
  // Flags only move at the edge after a result of their kind
  fast_flag_hold_a: assert property (!$past(raw_valid_i) |->
    $stable(fast_trip_flags_o)) else $error("fast flag moved");
  slow_flag_hold_a: assert property (!$past(avg_valid_i) |->
    $stable(slow_trip_flags_o)) else $error("slow flag moved");
  sum_trip_hold_a: assert property (!$past(cycle_done_i) |->
    $stable(sum_trip_o)) else $error("sum trip moved");
  read_wait_a: assert property (hsel_i && htrans_i[1] &&
    hready_i && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  write_nowait_a: assert property (hsel_i && htrans_i[1] &&
    hready_i && hwrite_i |=> hreadyout_o) else $error("write stalled");
  // The most negative value is never strictly above a limit; no total is above the top sum limit
  fast_floor_a: assert property (raw_valid_i &&
    raw_data_i[15:3] == 13'h1000 && raw_chan_i != 2'h3 |=>
    !fast_trip_flags_o[$past(raw_chan_i)]) else $error("fast floor trip");
  slow_floor_a: assert property (avg_valid_i &&
    avg_data_i[15:3] == 13'h1000 && avg_chan_i != 2'h3 |=>
    !slow_trip_flags_o[$past(avg_chan_i)]) else $error("slow floor trip");
  sum_ceiling_a: assert property (cycle_done_i &&
    sum_limit_i[15:1] == 15'h3FFF |=> !sum_trip_o)
    else $error("sum trip above ceiling");
endmodule : tslc_chk
bind tslc_top tslc_chk u_tslc_chk (.*);

// *** verif/tslc_host_model.sv ***
/*
  Bus master standing in for the host: single word transfers only.
  Assumes hready_i is the slave's hreadyout and one clock drives both.
*/
`timescale 1ns/100ps
module tslc_host_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  // Idle bus at time zero
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // Waits on hready with no assumed latency; stale lines are inverted
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {22'h0, idx, 2'h0};
    htrans_o <= 2'h2;
    hwrite_o <= w;
    hwdata_o <= ~hwdata_o;
    do @(posedge clk_i); while (!hready_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~haddr_o;
    hwdata_o <= wd;
    do @(posedge clk_i); while (!hready_i);
    rd = hrdata_i;
  endtask : xfer
endmodule : tslc_host_model
